// File: sim/cpu_core_model.sv
// Control CPU core model: watches group lines, acknowledges, collects vectors
`timescale 1ns/1ps
module cpu_core_model
  import irq_expander_pkg::*;
(
  input  wire logic                                   mclk,
  input  wire logic                                   rst_b,
  input  wire logic [31:0]                            want,
  input  wire logic [3:0]                             ack_delay,
  input  wire logic [irq_expander_pkg::NUM_GROUPS-1:0] cpu_int_q,
  input  wire logic                                   vector_valid_q,
  input  wire logic [irq_expander_pkg::VECTOR_W-1:0]  vector_q,
  input  wire logic [irq_expander_pkg::SLOT_AW-1:0]   vector_slot_q,
  output logic                                        cpu_ack,
  output logic [irq_expander_pkg::GROUP_AW-1:0]       cpu_ack_group,
  output logic [irq_expander_pkg::SLOT_AW-1:0]        taken_slot,
  output logic [irq_expander_pkg::VECTOR_W-1:0]       taken_vec,
  output logic [31:0]                                 served,
  output logic [31:0]                                 fetch_len
);
  int grp;
  int n;
  initial begin
    cpu_ack = 1'b0;
    cpu_ack_group = 4'hf;
    served = 0;
  end
  // Ack is a single-cycle pulse; the ack group number is inverted once it drops
  always begin
    @(posedge mclk);
    if (rst_b && served < want && |cpu_int_q) begin
      repeat (ack_delay) @(posedge mclk);
      grp = 0;
      for (int g = 11; g >= 0; g--) begin
        if (cpu_int_q[g]) grp = g;
      end
      cpu_ack <= 1'b1;
      cpu_ack_group <= 4'(grp);
      @(posedge mclk);
      cpu_ack <= 1'b0;
      cpu_ack_group <= ~4'(grp);
      n = 0;
      // Strobe and vector are taken at the edge that samples the strobe high
      while (n < 20 && vector_valid_q !== 1'b1) begin
        @(posedge mclk);
        n++;
      end
      fetch_len = n;
      taken_slot = vector_slot_q;
      taken_vec = vector_q;
      served = served + 1;
    end
  end
endmodule

// File: sim/peripheral_interrupt_expander_bench.sv
// Self-checking bench for the peripheral interrupt expander
`timescale 1ns/1ps
module peripheral_interrupt_expander_bench;
  import irq_expander_pkg::*;
  logic        mclk = 0, rst_b = 0, pwm_irq_eleven = 0, pwm_irq_twelve = 0;
  logic [95:0] periph_irq = '0, slot_enable = '0, group_flag_register_q, f0;
  logic [5:0]  dma_channel_irq = '0, dma_trigger_q;
  logic [7:0]  conv_one_eoc = '0, conv_two_eoc = '0, flag_wr_data = '0;
  logic [31:0] ipc_handshake = '0, vec_wr_data = '0, vector_q, ipc_status_q, tvec;
  logic        external_irq_three = 0, flash_single_error_irq = 0, ram_single_error_irq = 0;
  logic        ram_access_violation_irq = 0, ext_bus_interface_irq = 0, fpu_overflow_flag = 0;
  logic        fpu_underflow_flag = 0, mem_uncorrectable_error = 0, dma_ch1_high_req = 0;
  logic        flag_wr_en = 0, vec_wr_en = 0, cpu_ack, vector_valid_q, dma_ch1_high_q;
  logic        nmi_req_q, nmi_wdog_start_q;
  logic [11:0] dma_trig_sel = '0, cpu_int_q;
  logic [3:0]  flag_wr_group = '0, cpu_ack_group, dly = '0, other_cpu_irq_q, conv_dma_trig_q;
  logic [6:0]  vec_wr_addr = '0, vector_slot_q, tslot;
  logic [31:0] want = 0, served, flen;
  int          num_errors = 0, check_count = 0;

  always #12.5 mclk = ~mclk;

  peripheral_interrupt_expander dut (.mclk, .rst_b, .periph_irq, .slot_enable, .dma_channel_irq,
    .pwm_irq_eleven, .pwm_irq_twelve, .conv_one_eoc, .conv_two_eoc, .ipc_handshake,
    .external_irq_three, .flash_single_error_irq, .ram_single_error_irq,
    .ram_access_violation_irq, .ext_bus_interface_irq, .fpu_overflow_flag,
    .fpu_underflow_flag, .mem_uncorrectable_error, .dma_trig_sel, .dma_ch1_high_req,
    .flag_wr_en, .flag_wr_group, .flag_wr_data, .vec_wr_en, .vec_wr_addr, .vec_wr_data,
    .cpu_ack, .cpu_ack_group, .cpu_int_q, .group_flag_register_q, .vector_valid_q, .vector_q,
    .vector_slot_q, .ipc_status_q, .other_cpu_irq_q, .conv_dma_trig_q, .dma_trigger_q,
    .dma_ch1_high_q, .nmi_req_q, .nmi_wdog_start_q);

  cpu_core_model cpu (.mclk, .rst_b, .want, .ack_delay(dly), .cpu_int_q, .vector_valid_q,
    .vector_q, .vector_slot_q, .cpu_ack, .cpu_ack_group, .taken_slot(tslot),
    .taken_vec(tvec), .served, .fetch_len(flen));

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic vwr(input logic [6:0] a, input logic [31:0] d);
    @(posedge mclk);
    vec_wr_en <= 1'b1;
    vec_wr_addr <= a;
    vec_wr_data <= d;
    @(posedge mclk);
    vec_wr_en <= 1'b0;
  endtask

  task automatic fwr(input logic [3:0] g, input logic [7:0] d);
    @(posedge mclk);
    flag_wr_en <= 1'b1;
    flag_wr_group <= g;
    flag_wr_data <= d;
    @(posedge mclk);
    flag_wr_en <= 1'b0;
    tick(2);
  endtask

  // Slow or prompt CPU answer, then judge slot, vector and fetch length
  task automatic svc(input logic [3:0] d, input logic [6:0] s, input logic [31:0] v);
    int i;
    dly = d;
    want = want + 1;
    for (i = 0; i < 60 && served != want; i++) tick(1);
    if (served != want) begin
      num_errors++;
      close_out();
    end
    chk(tslot, s, "vector slot");
    chk(tvec, v, "vector value");
    chk(flen, SERVICE_CYCLES, "fetch length");
  endtask

  task automatic t_service();
    vwr(7'd48, 32'h0000_0da0);
    vwr(7'd49, 32'h0000_0da2);
    @(posedge mclk);
    slot_enable[49:48] <= 2'b11;
    dma_channel_irq <= 6'h03;
    tick(3);
    chk(cpu_int_q, 12'h040, "group 7 line");
    svc(4'd0, 7'd48, 32'h0000_0da0);
    chk(group_flag_register_q[49:48], 2'b10, "second flag kept");
    svc(4'd3, 7'd49, 32'h0000_0da2);
    tick(2);
    chk(cpu_int_q, 12'h000, "line drops");
  endtask

  // Software slot only in an unassigned slot of group 11, so no peripheral request is lost
  task automatic t_soft();
    fwr(4'd10, 8'h80);
    chk(group_flag_register_q[87:80], 8'h80, "soft flag");
    chk(cpu_int_q[10], 1'b0, "masked soft flag");
    @(posedge mclk);
    slot_enable[87] <= 1'b1;
    tick(3);
    chk(cpu_int_q[10], 1'b1, "soft line");
    f0 = group_flag_register_q;
    fwr(4'd12, 8'hff);
    chk(group_flag_register_q, f0, "bad group ignored");
    fwr(4'd10, 8'h00);
    chk(cpu_int_q[10], 1'b0, "soft clear");
  endtask

  task automatic t_conv();
    @(posedge mclk);
    conv_one_eoc <= 8'hff;
    conv_two_eoc <= 8'h5a;
    dma_trig_sel <= 12'h4e4;
    dma_ch1_high_req <= 1'b1;
    tick(2);
    chk(group_flag_register_q[79:72], 8'h5a, "converter and");
    chk(conv_dma_trig_q, 4'ha, "converter dma");
    chk(dma_trigger_q, 6'h2a, "dma select");
    chk(dma_ch1_high_q, 1'b1, "ch1 priority");
  endtask

  task automatic t_route();
    int n;
    f0 = group_flag_register_q;
    n = 0;
    @(posedge mclk);
    ipc_handshake <= 32'h8000_0005;
    mem_uncorrectable_error <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      n += nmi_wdog_start_q;
    end
    chk(ipc_status_q, 32'h8000_0005, "ipc poll");
    chk(other_cpu_irq_q, 4'h5, "ipc other cpu");
    chk(nmi_req_q, 1'b1, "nmi level");
    chk(n, 1, "watchdog pulse");
    chk(group_flag_register_q, {f0[95:84], 4'h5, f0[79:0]}, "only ipc slots");
    vwr(7'd91, 32'h0000_0df6);
    @(posedge mclk);
    slot_enable[91] <= 1'b1;
    ram_single_error_irq <= 1'b1;
    tick(3);
    chk(cpu_int_q[11], 1'b1, "single error line");
    svc(4'd1, 7'd91, 32'h0000_0df6);
    @(posedge mclk);
    ram_single_error_irq <= 1'b0;
  endtask

  task automatic t_reserved();
    @(posedge mclk);
    periph_irq <= '1;
    {fpu_underflow_flag, fpu_overflow_flag, ext_bus_interface_irq} <= 3'h7;
    {ram_access_violation_irq, ram_single_error_irq} <= 2'h3;
    {flash_single_error_irq, external_irq_three} <= 2'h3;
    {pwm_irq_eleven, pwm_irq_twelve} <= 2'h3;
    tick(3);
    chk(group_flag_register_q & ~USED_MASK, 96'h0, "reserved never set");
    chk(group_flag_register_q[95:88], 8'hfb, "group 12 map");
    chk(group_flag_register_q[55:54], 2'h3, "pulse-modulator slots");
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_service();
    t_soft();
    t_conv();
    t_route();
    t_reserved();
    close_out();
  end
endmodule

// File: src/irq_expander_pkg.sv
// Constants, types and helpers for the peripheral interrupt expander
// How it works
// - The 96 slots form twelve groups of eight, each drives one CPU line and holds 8 pending.
// - Every slot has its own enable so each source is masked or passed on its own.
// - Each slot has its own writable vector, and a service takes eight clocks to supply it.
// - Only 72 slots carry peripheral sources and the reserved ones are never driven by hardware.
// - Each of the six DMA channels owns a slot for its transfer start or done event.
// - Each DMA channel picks its trigger separately, and only channel 1 may take high priority.
// - Uncorrectable memory errors go to the non-maskable path and start its watchdog.
// - Correctable memory errors become ordinary maskable slot requests.
// - 32 handshake channels can be polled, and four also interrupt both this and the other CPU.
// - Each of eight converter interrupts is the AND of the matching outputs of both converters.
// - All eight combined converter interrupts reach the slots, only four reach the DMA.
package irq_expander_pkg;
  localparam int unsigned NUM_GROUPS  = 12;
  localparam int unsigned GROUP_SIZE  = 8;
  localparam int unsigned NUM_SLOTS   = 96;
  localparam int unsigned SLOT_AW     = 7;
  localparam int unsigned GROUP_AW    = 4;
  localparam int unsigned VECTOR_W    = 32;
  localparam int unsigned NUM_DMA     = 6;
  localparam int unsigned NUM_IPC     = 32;
  localparam int unsigned NUM_IPC_IRQ = 4;
  localparam int unsigned NUM_CONV    = 8;
  localparam int unsigned NUM_CONV_DMA = 4;
  // Slots wired to a peripheral, group 1 in the low byte
  localparam logic [95:0] USED_MASK   = 96'hfb0fff0303fff3c7ffffffdb;
  localparam int unsigned DMA_BASE    = 48;
  localparam int unsigned CONV_BASE   = 72;
  localparam int unsigned IPC_BASE    = 80;
  localparam int unsigned MISC_BASE   = 88;
  localparam int unsigned RAM_SINGLE_SLOT = 91;
  localparam int unsigned SERVICE_CYCLES = 8;
  localparam logic [3:0]  SERVICE_LAST = 4'h7;

  typedef enum logic [1:0] {
    SVC_IDLE  = 2'b00,
    SVC_FETCH = 2'b01,
    SVC_DONE  = 2'b11
  } svc_state_t;

  // Lowest pending slot of a group wins
  function automatic logic [3:0] first_slot(input logic [7:0] pend);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
endpackage

// File: src/peripheral_interrupt_expander.sv
// Peripheral interrupt expander: slot flags, enables, group lines, vector fetch and routing
`timescale 1ns/1ps
module peripheral_interrupt_expander
  import irq_expander_pkg::*;
(
  input  wire logic                                   mclk,
  input  wire logic                                   rst_b,
  input  wire logic [irq_expander_pkg::NUM_SLOTS-1:0] periph_irq,
  input  wire logic [irq_expander_pkg::NUM_SLOTS-1:0] slot_enable,
  input  wire logic [irq_expander_pkg::NUM_DMA-1:0]   dma_channel_irq,
  input  wire logic                                   pwm_irq_eleven,
  input  wire logic                                   pwm_irq_twelve,
  input  wire logic [irq_expander_pkg::NUM_CONV-1:0]  conv_one_eoc,
  input  wire logic [irq_expander_pkg::NUM_CONV-1:0]  conv_two_eoc,
  input  wire logic [irq_expander_pkg::NUM_IPC-1:0]   ipc_handshake,
  input  wire logic                                   external_irq_three,
  input  wire logic                                   flash_single_error_irq,
  input  wire logic                                   ram_single_error_irq,
  input  wire logic                                   ram_access_violation_irq,
  input  wire logic                                   ext_bus_interface_irq,
  input  wire logic                                   fpu_overflow_flag,
  input  wire logic                                   fpu_underflow_flag,
  input  wire logic                                   mem_uncorrectable_error,
  input  wire logic [11:0]                            dma_trig_sel,
  input  wire logic                                   dma_ch1_high_req,
  input  wire logic                                   flag_wr_en,
  input  wire logic [irq_expander_pkg::GROUP_AW-1:0]  flag_wr_group,
  input  wire logic [7:0]                             flag_wr_data,
  input  wire logic                                   vec_wr_en,
  input  wire logic [irq_expander_pkg::SLOT_AW-1:0]   vec_wr_addr,
  input  wire logic [irq_expander_pkg::VECTOR_W-1:0]  vec_wr_data,
  input  wire logic                                   cpu_ack,
  input  wire logic [irq_expander_pkg::GROUP_AW-1:0]  cpu_ack_group,
  output logic [irq_expander_pkg::NUM_GROUPS-1:0]     cpu_int_q,
  output logic [irq_expander_pkg::NUM_SLOTS-1:0]      group_flag_register_q,
  output logic                                        vector_valid_q,
  output logic [irq_expander_pkg::VECTOR_W-1:0]       vector_q,
  output logic [irq_expander_pkg::SLOT_AW-1:0]        vector_slot_q,
  output logic [irq_expander_pkg::NUM_IPC-1:0]        ipc_status_q,
  output logic [irq_expander_pkg::NUM_IPC_IRQ-1:0]    other_cpu_irq_q,
  output logic [irq_expander_pkg::NUM_CONV_DMA-1:0]   conv_dma_trig_q,
  output logic [irq_expander_pkg::NUM_DMA-1:0]        dma_trigger_q,
  output logic                                        dma_ch1_high_q,
  output logic                                        nmi_req_q,
  output logic                                        nmi_wdog_start_q
);
  import irq_expander_pkg::*;

  logic [NUM_SLOTS-1:0] src;
  logic [NUM_SLOTS-1:0] src_q;
  logic [NUM_SLOTS-1:0] rise;
  logic [NUM_SLOTS-1:0] flag_d;
  logic [NUM_SLOTS-1:0] pend;
  logic [NUM_CONV-1:0]  conv_irq;
  logic [VECTOR_W-1:0]  vec_mem [NUM_SLOTS];
  svc_state_t           state_q;
  svc_state_t           state_d;
  logic [3:0]           cnt_q;
  logic [SLOT_AW-1:0]   svc_slot_q;
  logic [3:0]           pick;
  logic                 svc_start;
  logic                 uncorr_q;

  assign conv_irq = conv_one_eoc & conv_two_eoc;

  always_comb begin
    src = periph_irq & USED_MASK;
    src[DMA_BASE +: 8] = {pwm_irq_eleven, pwm_irq_twelve, dma_channel_irq};
    src[CONV_BASE +: 8] = conv_irq;
    src[IPC_BASE +: 8] = {4'h0, ipc_handshake[NUM_IPC_IRQ-1:0]};
    src[MISC_BASE +: 8] = {fpu_underflow_flag, fpu_overflow_flag, ext_bus_interface_irq,
                           ram_access_violation_irq, ram_single_error_irq, 1'b0,
                           flash_single_error_irq, external_irq_three};
  end

  assign rise = src & ~src_q;
  assign pend = group_flag_register_q & slot_enable;
  assign pick = first_slot(pend[cpu_ack_group*8 +: 8]);
  assign svc_start = (state_q == SVC_IDLE) && cpu_ack && (cpu_ack_group < 4'(NUM_GROUPS))
                     && (pick != 4'h8);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_q <= '0;
    end else begin
      src_q <= src;
    end
  end

  always_comb begin
    flag_d = group_flag_register_q;
    if (flag_wr_en && (flag_wr_group < 4'(NUM_GROUPS))) begin
      flag_d[flag_wr_group*8 +: 8] = flag_wr_data;
    end
    if (svc_start) begin
      flag_d[cpu_ack_group*8 + 32'(pick)] = 1'b0;
    end
    // new events win over any clear
    flag_d = flag_d | rise;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      group_flag_register_q <= '0;
    end else begin
      group_flag_register_q <= flag_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_int_q <= '0;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        cpu_int_q[g] <= |pend[g*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (vec_wr_en && (vec_wr_addr < 7'(NUM_SLOTS))) begin
      vec_mem[vec_wr_addr] <= vec_wr_data;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SVC_IDLE: begin
        if (svc_start) begin
          state_d = SVC_FETCH;
        end
      end
      SVC_FETCH: begin
        if (cnt_q == SERVICE_LAST - 4'h1) begin
          state_d = SVC_DONE;
        end
      end
      SVC_DONE: state_d = SVC_IDLE;
      default: state_d = SVC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SVC_IDLE;
      cnt_q <= 4'h0;
      svc_slot_q <= 7'h00;
    end else begin
      state_q <= state_d;
      if (svc_start) begin
        cnt_q <= 4'h0;
        svc_slot_q <= 7'(cpu_ack_group * 8) + 7'(pick);
      end else if (state_q == SVC_FETCH) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Vector leaves on the eighth edge after the acknowledge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vector_valid_q <= 1'b0;
      vector_q <= '0;
      vector_slot_q <= 7'h00;
    end else begin
      vector_valid_q <= (state_q == SVC_FETCH) && (cnt_q == SERVICE_LAST - 4'h1);
      if ((state_q == SVC_FETCH) && (cnt_q == SERVICE_LAST - 4'h1)) begin
        vector_q <= vec_mem[svc_slot_q];
        vector_slot_q <= svc_slot_q;
      end
    end
  end

  // polled channels and other CPU lines
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ipc_status_q <= '0;
      other_cpu_irq_q <= '0;
    end else begin
      ipc_status_q <= ipc_handshake;
      other_cpu_irq_q <= ipc_handshake[NUM_IPC_IRQ-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      conv_dma_trig_q <= '0;
      dma_trigger_q <= '0;
      dma_ch1_high_q <= 1'b0;
    end else begin
      conv_dma_trig_q <= conv_irq[NUM_CONV_DMA-1:0];
      for (int c = 0; c < NUM_DMA; c++) begin
        dma_trigger_q[c] <= conv_irq[dma_trig_sel[c*2 +: 2]];
      end
      dma_ch1_high_q <= dma_ch1_high_req;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      uncorr_q <= 1'b0;
      nmi_req_q <= 1'b0;
      nmi_wdog_start_q <= 1'b0;
    end else begin
      uncorr_q <= mem_uncorrectable_error;
      nmi_req_q <= mem_uncorrectable_error;
      nmi_wdog_start_q <= mem_uncorrectable_error && !uncorr_q;
    end
  end

  sequence svc_begin_s;
    svc_start;
  endsequence

  sequence svc_finish_s;
    !vector_valid_q [*7] ##1 vector_valid_q;
  endsequence

  chk_group_line_or: assert property (@(posedge mclk) disable iff (!rst_b)
    cpu_int_q[0] == $past(|pend[7:0]) && cpu_int_q[11] == $past(|pend[95:88]))
    else $error("group line does not follow enabled flags");
  chk_mask_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
    (pend[7:0] == 8'h00) |=> !cpu_int_q[0])
    else $error("disabled slots raised a group line");
  chk_vector_timing: assert property (@(posedge mclk) disable iff (!rst_b)
    svc_begin_s |=> svc_finish_s)
    else $error("vector not supplied on the eighth clock");
  chk_reserved_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    ((group_flag_register_q & ~USED_MASK & ~$past(group_flag_register_q)) != '0)
    |-> $past(flag_wr_en))
    else $error("reserved slot set without a software write");
  chk_dma_slot_set: assert property (@(posedge mclk) disable iff (!rst_b)
    (dma_channel_irq[0] && !src_q[DMA_BASE]) |=> group_flag_register_q[DMA_BASE])
    else $error("DMA event did not set its slot");
  chk_dma_trig_sel: assert property (@(posedge mclk) disable iff (!rst_b)
    dma_trigger_q[5] == $past(conv_irq[dma_trig_sel[11:10]]))
    else $error("DMA trigger does not follow its select");
  chk_nmi_route: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(mem_uncorrectable_error) |=> nmi_req_q && nmi_wdog_start_q ##1 !nmi_wdog_start_q)
    else $error("uncorrectable error not routed to NMI");
  chk_single_err_slot: assert property (@(posedge mclk) disable iff (!rst_b)
    (ram_single_error_irq && !src_q[RAM_SINGLE_SLOT]) |=> group_flag_register_q[RAM_SINGLE_SLOT])
    else $error("single error did not set its slot");
  chk_ipc_both_sides: assert property (@(posedge mclk) disable iff (!rst_b)
    other_cpu_irq_q == $past(src[IPC_BASE +: 4]))
    else $error("handshake interrupt not mirrored to other CPU");
  chk_conv_and_trig: assert property (@(posedge mclk) disable iff (!rst_b)
    conv_dma_trig_q == $past(conv_one_eoc[3:0] & conv_two_eoc[3:0]))
    else $error("converter DMA trigger is not the AND of both");
endmodule
